// *** sram_device.sv ***
// synchronous burst sram end: control registers, burst counter, flow-through read path
// Overview of operation
// R1 - all state moves on rising clock; output enable asynchronous
// R2 - write data registered, read data flow-through
// R3 - static order select: high interleaved, low linear
// R4 - data driven only while output enable low
// R5 - controller may tie output enable low permanently
// R6 - selected load: write or read, data next cycle
// R7 - advance steps counter, keeps loaded read/write kind
// R8 - deselected load stops burst, bus floats next cycle
// R9 - clock gate high freezes everything like no edge
// R10 - selected only when all three enables true
// R11 - data lines float from power-up onward
// R12 - each lane select gates eight bits plus parity
// R13 - any lane mix; none writes nothing; reads ignore
// R14 - load captures address; advance ignores address lines
// R15 - two low bits: xor or add count, wrap
// R16 - advance after deselect or no-op does nothing
// R17 - controller gives lane selects every burst write cycle
// R18 - 131072 words of 36 bits, 17-bit address
`timescale 1ns/1ps
module sram_device (
    input wire logic clk,
    input wire logic resetn,
    sram_bus_if.device bus
);
    // control registers, burst counter and the data-in register; the array is kept apart
    typedef struct packed {
        logic active;
        logic burstWrite;
        sram_pkg::addr_t base;
        sram_pkg::burst_t count;
        sram_pkg::phase_t phase;
        sram_pkg::addr_t phaseAddr;
        sram_pkg::lanes_t phaseLanes;
        logic pendWrite;
        sram_pkg::addr_t pendAddr;
        sram_pkg::lanes_t pendLanes;
        sram_pkg::word_t dataIn;
    } dev_state_t;

    localparam dev_state_t DEV_RESET = '{
        active: 1'b0,
        burstWrite: 1'b0,
        base: '0,
        count: sram_pkg::BURST_FIRST,
        phase: sram_pkg::PH_IDLE,
        phaseAddr: '0,
        phaseLanes: '0,
        pendWrite: 1'b0,
        pendAddr: '0,
        pendLanes: '0,
        dataIn: '0
    };

    // the whole control state sits in cur, registered once per clock
    dev_state_t cur;
    dev_state_t next_cur;

    // array kept apart from the state struct: it is far too large to copy each cycle
    sram_pkg::word_t storage [sram_pkg::DEPTH]; // see R18

    logic selected;
    logic edgeTaken;
    sram_pkg::burst_t stepCount;
    sram_pkg::burst_t burstLow;
    sram_pkg::word_t arrayRead;
    sram_pkg::word_t arrayOld;
    sram_pkg::word_t readWord;
    sram_pkg::word_t mergedWord;
    logic anyLane;
    logic readPhase;

    // kind of control cycle that the current edge carries
    typedef enum logic [2:0] {
        CYC_SUSPEND = 3'b000,
        CYC_LOAD = 3'b001,
        CYC_DESELECT = 3'b010,
        CYC_ADVANCE = 3'b011,
        CYC_NOOP = 3'b100
    } cycle_kind_t;

    cycle_kind_t cycleKind;

    // all three enables must be true; a single false one deselects
    assign selected = !bus.selectAN && !bus.selectCN && bus.selectB; // see R10
    assign edgeTaken = !bus.clkGateN; // see R9

    // one decode of the control pins, so each kind of cycle is handled in one branch below
    always_comb begin
        if (!edgeTaken) begin // see R9
            cycleKind = CYC_SUSPEND;
        end else if (!bus.advanceOrLoadN) begin
            if (selected) begin // see R10
                cycleKind = CYC_LOAD;
            end else begin
                cycleKind = CYC_DESELECT;
            end
        end else if (cur.active) begin
            cycleKind = CYC_ADVANCE;
        end else begin
            cycleKind = CYC_NOOP;
        end
    end

    // burst order on the two low address bits
    assign stepCount = sram_pkg::burst_t'(cur.count + sram_pkg::BURST_STEP);
    always_comb begin
        if (bus.burstOrderSel) begin
            burstLow = cur.base[sram_pkg::BURST_W-1:0] ^ stepCount; // see R3, R15
        end else begin
            burstLow = sram_pkg::burst_t'(cur.base[sram_pkg::BURST_W-1:0] + stepCount); // see R15
        end
    end

    // two read ports: one for the data phase, one for the lane merge of the pending write
    assign arrayRead = storage[cur.phaseAddr];
    assign arrayOld = storage[cur.pendAddr];

    // per lane: merge for the array write, and forward a write not yet in the array
    genvar lane;
    generate
        for (lane = 0; lane < sram_pkg::LANES; lane++) begin : g_lane
            localparam int LO = lane * sram_pkg::LANE_BITS;
            localparam int PAR = sram_pkg::DATA_BITS + lane;
            // forward only the lanes that the pending write really changes
            logic fwd;
            assign fwd = cur.pendWrite && cur.pendLanes[lane] && (cur.pendAddr == cur.phaseAddr);
            assign mergedWord[LO +: sram_pkg::LANE_BITS] = cur.pendLanes[lane] ?
                cur.dataIn[LO +: sram_pkg::LANE_BITS] : arrayOld[LO +: sram_pkg::LANE_BITS]; // see R12
            assign mergedWord[PAR] = cur.pendLanes[lane] ? cur.dataIn[PAR] : arrayOld[PAR]; // see R12
            assign readWord[LO +: sram_pkg::LANE_BITS] = fwd ?
                cur.dataIn[LO +: sram_pkg::LANE_BITS] : arrayRead[LO +: sram_pkg::LANE_BITS];
            assign readWord[PAR] = fwd ? cur.dataIn[PAR] : arrayRead[PAR];
        end
    endgenerate

    always_comb begin
        next_cur = cur;
        // data phase ending now: capture the write word into the input register
        if (cycleKind != CYC_SUSPEND) begin
            next_cur.pendWrite = 1'b0;
            if (cur.phase == sram_pkg::PH_WRITE) begin
                next_cur.pendWrite = 1'b1; // see R2
                next_cur.pendAddr = cur.phaseAddr;
                next_cur.pendLanes = cur.phaseLanes; // see R13
                next_cur.dataIn = bus.dataBus; // see R2
            end
        end
        unique case (cycleKind)
            CYC_SUSPEND: begin
                // the edge is blocked: the data phase and the burst stay exactly as they were
                next_cur.phase = cur.phase; // see R9
            end
            CYC_LOAD: begin
                // the external address and the read/write line are taken only here
                next_cur.active = 1'b1; // see R6, R14
                next_cur.burstWrite = !bus.readNotWrite;
                next_cur.base = bus.addr;
                next_cur.count = sram_pkg::BURST_FIRST;
                next_cur.phaseAddr = bus.addr;
                next_cur.phaseLanes = ~bus.laneWriteSelN; // see R12
                next_cur.phase = bus.readNotWrite ? sram_pkg::PH_READ : sram_pkg::PH_WRITE; // see R6
            end
            CYC_DESELECT: begin
                // a write still in the input register lands anyway; only the burst ends
                next_cur.active = 1'b0; // see R8
                next_cur.phase = sram_pkg::PH_IDLE; // see R8
            end
            CYC_ADVANCE: begin
                // read/write line and address lines ignored while advancing
                next_cur.count = stepCount; // see R7, R15
                next_cur.phaseAddr = {cur.base[sram_pkg::ADDR_W-1:sram_pkg::BURST_W], burstLow}; // see R14
                next_cur.phaseLanes = ~bus.laneWriteSelN; // see R17
                next_cur.phase = cur.burstWrite ? sram_pkg::PH_WRITE : sram_pkg::PH_READ; // see R7
            end
            CYC_NOOP: begin
                // no burst to continue: nothing happens and the bus floats
                next_cur.phase = sram_pkg::PH_IDLE; // see R16
            end
            default: begin
                // unused codes behave like a blocked edge
                next_cur = cur;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin // see R1
        if (!resetn) begin
            cur <= DEV_RESET; // see R11
        end else begin
            cur <= next_cur;
        end
    end

    // a captured write reaches the array on the next taken edge; reads forward it until then
    // a word with no lane chosen is skipped, so the array sees no needless read-modify-write
    assign anyLane = |cur.pendLanes; // see R13
    always_ff @(posedge clk) begin
        if (edgeTaken && cur.pendWrite && anyLane) begin
            storage[cur.pendAddr] <= mergedWord; // see R13
        end
    end

    // flow-through: the array word goes straight to the pins, enabled by the read phase and the async enable
    assign bus.devData = readWord; // see R2
    assign readPhase = (cur.phase == sram_pkg::PH_READ);
    assign bus.devDataOe = readPhase && !bus.outEnableN; // see R4, R5, R8
endmodule

// *** sram_pkg.sv ***
// shared constants and types for the synchronous burst sram and its controller
package sram_pkg;
    localparam int ADDR_W = 17;
    localparam int DEPTH = 131072;
    localparam int LANES = 4;
    localparam int LANE_BITS = 8;
    localparam int DATA_BITS = LANES * LANE_BITS;
    localparam int WORD_W = DATA_BITS + LANES;
    localparam int BURST_W = 2;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [WORD_W-1:0] word_t;
    typedef logic [LANES-1:0] lanes_t;
    typedef logic [BURST_W-1:0] burst_t;

    localparam burst_t BURST_FIRST = 2'h0;
    localparam burst_t BURST_STEP = 2'h1;

    // data phase that follows a control cycle
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_READ = 2'b01,
        PH_WRITE = 2'b10
    } phase_t;

    // commands accepted by the controller end
    typedef enum logic [1:0] {
        CMD_READ = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_ADVANCE = 2'b10,
        CMD_STOP = 2'b11
    } cmd_t;
endpackage

// *** sram_bus_if.sv ***
// pins between the burst sram and its controller
`timescale 1ns/1ps
interface sram_bus_if;
    sram_pkg::addr_t addr;
    logic readNotWrite;
    logic advanceOrLoadN;
    logic clkGateN;
    logic selectAN;
    logic selectCN;
    logic selectB;
    sram_pkg::lanes_t laneWriteSelN;
    logic burstOrderSel;
    logic outEnableN;
    sram_pkg::word_t hostData;
    logic hostDataOe;
    sram_pkg::word_t devData;
    logic devDataOe;
    sram_pkg::word_t dataBus;
    logic dataDriven;

    // shared data lines resolved from the two enables; undriven reads as zero
    assign dataDriven = hostDataOe | devDataOe;
    assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : '0);

    modport device (
        input addr, readNotWrite, advanceOrLoadN, clkGateN, selectAN, selectCN, selectB,
        input laneWriteSelN, burstOrderSel, outEnableN, dataBus,
        output devData, devDataOe
    );
    modport host (
        output addr, readNotWrite, advanceOrLoadN, clkGateN, selectAN, selectCN, selectB,
        output laneWriteSelN, burstOrderSel, outEnableN, hostData, hostDataOe,
        input dataBus
    );
endinterface

// *** sram_host.sv ***
// controller end: turns user commands into sram pin cycles and collects read data
`timescale 1ns/1ps
module sram_host (
    input wire logic clk,
    input wire logic resetn,
    sram_bus_if.host bus,
    input wire logic cmdValid,
    input wire sram_pkg::cmd_t cmdKind,
    input wire sram_pkg::addr_t cmdAddr,
    input wire sram_pkg::lanes_t cmdLanes,
    input wire sram_pkg::word_t cmdWriteData,
    input wire logic hold,
    input wire logic interleaved,
    output logic cmdReady,
    output sram_pkg::word_t rdData,
    output logic rdValid
);
    typedef struct packed {
        logic cenN;
        logic advLdN;
        logic readNotWrite;
        logic deselN;
        sram_pkg::addr_t addr;
        sram_pkg::lanes_t lanes;
        sram_pkg::phase_t presKind;
        sram_pkg::word_t presData;
        logic active;
        logic burstWrite;
        sram_pkg::phase_t phase;
        sram_pkg::word_t phaseData;
        sram_pkg::word_t rdData;
        logic rdValid;
    } host_state_t;

    // reset presents a deselect so the device starts idle
    localparam host_state_t HOST_RESET = '{
        cenN: 1'b0,
        advLdN: 1'b0,
        readNotWrite: 1'b1,
        deselN: 1'b1,
        addr: '0,
        lanes: '0,
        presKind: sram_pkg::PH_IDLE,
        presData: '0,
        active: 1'b0,
        burstWrite: 1'b0,
        phase: sram_pkg::PH_IDLE,
        phaseData: '0,
        rdData: '0,
        rdValid: 1'b0
    };

    host_state_t cur;
    host_state_t next_cur;

    assign cmdReady = !hold;

    always_comb begin
        next_cur = cur;
        next_cur.rdValid = 1'b0;
        // the device only sees this edge when the presented gate is low
        if (!cur.cenN) begin // see R9
            next_cur.phase = cur.presKind; // see R6
            next_cur.phaseData = cur.presData;
            if (cur.phase == sram_pkg::PH_READ) begin
                next_cur.rdData = bus.dataBus;
                next_cur.rdValid = 1'b1;
            end
        end
        next_cur.cenN = hold;
        if (!hold) begin
            next_cur.advLdN = 1'b0;
            next_cur.deselN = 1'b1;
            next_cur.presKind = sram_pkg::PH_IDLE;
            next_cur.active = 1'b0;
            next_cur.lanes = cmdLanes; // see R17
            next_cur.presData = cmdWriteData;
            if (cmdValid) begin
                unique case (cmdKind)
                    sram_pkg::CMD_READ, sram_pkg::CMD_WRITE: begin
                        next_cur.deselN = 1'b0; // see R10
                        next_cur.addr = cmdAddr;
                        next_cur.readNotWrite = (cmdKind == sram_pkg::CMD_READ);
                        next_cur.burstWrite = (cmdKind == sram_pkg::CMD_WRITE);
                        next_cur.active = 1'b1;
                        next_cur.presKind = (cmdKind == sram_pkg::CMD_READ) ?
                            sram_pkg::PH_READ : sram_pkg::PH_WRITE; // see R6
                    end
                    sram_pkg::CMD_ADVANCE: begin
                        next_cur.advLdN = 1'b1;
                        next_cur.active = cur.active;
                        if (cur.active) begin
                            next_cur.presKind = cur.burstWrite ? sram_pkg::PH_WRITE : sram_pkg::PH_READ; // see R7
                        end
                    end
                    sram_pkg::CMD_STOP: begin
                        next_cur.active = 1'b0; // see R8
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= HOST_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign bus.addr = cur.addr;
    assign bus.readNotWrite = cur.readNotWrite;
    assign bus.advanceOrLoadN = cur.advLdN;
    assign bus.clkGateN = cur.cenN;
    assign bus.selectAN = cur.deselN;
    assign bus.selectCN = 1'b0;
    assign bus.selectB = 1'b1;
    assign bus.laneWriteSelN = ~cur.lanes; // see R12
    assign bus.burstOrderSel = interleaved; // see R3
    assign bus.outEnableN = 1'b0; // see R5
    assign bus.hostData = cur.phaseData;
    assign bus.hostDataOe = (cur.phase == sram_pkg::PH_WRITE);
    assign rdData = cur.rdData;
    assign rdValid = cur.rdValid;
endmodule

// *** sram_asserts.sv ***
// pin checks between the burst sram and its controller
`timescale 1ns/1ps
module sram_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic readNotWrite,
    input wire logic advanceOrLoadN,
    input wire logic clkGateN,
    input wire logic selectAN,
    input wire logic selectCN,
    input wire logic selectB,
    input wire logic outEnableN,
    input wire sram_pkg::word_t devData,
    input wire logic devDataOe,
    input wire logic hostDataOe,
    input wire logic dataDriven
);
    logic sel;
    logic load;
    logic adv;
    assign sel = !selectAN && !selectCN && selectB;
    assign load = !clkGateN && !advanceOrLoadN;
    assign adv = !clkGateN && advanceOrLoadN;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_oe; devDataOe |-> !outEnableN && !hostDataOe; endproperty
    a_oe: assert property (p_oe) else $error("drive without oe or against the host");
    property p_oe_tied; !outEnableN; endproperty
    a_oe_tied: assert property (p_oe_tied) else $error("oe toggled");
    property p_rd; load && sel && readNotWrite |=> devDataOe && !hostDataOe; endproperty
    a_rd: assert property (p_rd) else $error("no read data phase");
    property p_wr; load && sel && !readNotWrite |=> hostDataOe && !devDataOe; endproperty
    a_wr: assert property (p_wr) else $error("no write data phase");
    property p_desel; load && !sel |=> !dataDriven; endproperty
    a_desel: assert property (p_desel) else $error("bus driven after deselect");
    // data only has to hold while it is actually driven
    property p_susp; clkGateN |=> $stable(devDataOe) && (!devDataOe || $stable(devData)); endproperty
    a_susp: assert property (p_susp) else $error("suspend changed output");
    property p_noop; adv && !dataDriven |=> !dataDriven; endproperty
    a_noop: assert property (p_noop) else $error("noop drove bus");
    property p_burst; adv && dataDriven |=> $stable(devDataOe) && $stable(hostDataOe); endproperty
    a_burst: assert property (p_burst) else $error("burst changed kind");
    c_burst_rd: cover property (load && sel && readNotWrite ##1 adv ##1 adv);
    c_wr: cover property (load && sel && !readNotWrite);
    c_susp: cover property (clkGateN && devDataOe);
    c_desel: cover property (load && !sel ##1 adv);
endmodule

// *** sync_sram_flowthrough_burst_test.sv ***
// bench joining the burst sram and its controller through their shared pins
`timescale 1ns/1ps
module sync_sram_flowthrough_burst_test;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic cmdValid = 1'h0;
    sram_pkg::cmd_t cmdKind = sram_pkg::CMD_STOP;
    sram_pkg::addr_t cmdAddr = 17'h0;
    sram_pkg::lanes_t cmdLanes = 4'h0;
    sram_pkg::word_t cmdWriteData = 36'h0;
    logic hold = 1'h0;
    logic interleaved = 1'h0;
    logic cmdReady;
    sram_pkg::word_t rdData;
    logic rdValid;
    int error_cnt = 0;
    int compares = 0;
    sram_pkg::word_t got[$];
    sram_pkg::word_t want[$];
    sram_bus_if sram_bus_if_inst ();
    sram_device sram_device_inst (.clk(clk), .resetn(resetn), .bus(sram_bus_if_inst));
    sram_host sram_host_inst (.clk(clk), .resetn(resetn), .bus(sram_bus_if_inst), .cmdValid(cmdValid),
        .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdLanes(cmdLanes), .cmdWriteData(cmdWriteData), .hold(hold),
        .interleaved(interleaved), .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid));
    sram_asserts sram_asserts_inst (.clk(clk), .resetn(resetn), .readNotWrite(sram_bus_if_inst.readNotWrite),
        .advanceOrLoadN(sram_bus_if_inst.advanceOrLoadN), .clkGateN(sram_bus_if_inst.clkGateN),
        .selectAN(sram_bus_if_inst.selectAN), .selectCN(sram_bus_if_inst.selectCN),
        .selectB(sram_bus_if_inst.selectB), .outEnableN(sram_bus_if_inst.outEnableN),
        .devData(sram_bus_if_inst.devData), .devDataOe(sram_bus_if_inst.devDataOe),
        .hostDataOe(sram_bus_if_inst.hostDataOe), .dataDriven(sram_bus_if_inst.dataDriven));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(negedge clk) begin
        if (rdValid === 1'h1) got.push_back(rdData);
    end
    task automatic check(input string what, input sram_pkg::word_t exp, input sram_pkg::word_t seen);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input sram_pkg::cmd_t k, input sram_pkg::addr_t a, input sram_pkg::lanes_t l,
            input sram_pkg::word_t d);
        @(negedge clk);
        cmdValid = 1'h1;
        cmdKind = k;
        cmdAddr = a;
        cmdLanes = l;
        cmdWriteData = d;
    endtask
    // reads are matched by order only, so a lost or extra word shows in the count
    task automatic settle();
        repeat (6) @(negedge clk) cmdValid = 1'h0;
        check("read count", 36'(want.size()), 36'(got.size()));
        foreach (want[i]) if (i < got.size()) check("read word", want[i], got[i]);
        want.delete();
        got.delete();
    endtask
    function automatic logic [1:0] seq(input logic [1:0] s, input int i);
        return interleaved ? (s ^ 2'(i)) : (s + 2'(i));
    endfunction
    task automatic s_write_read();
        sram_pkg::addr_t a[3] = '{17'h00000, 17'h1FFFF, 17'h0AAAA};
        foreach (a[i]) begin
            issue(sram_pkg::CMD_WRITE, a[i], 4'hF, {19'(i + 1), a[i]});
            issue(sram_pkg::CMD_READ, a[i], 4'h0, 36'h0);
            want.push_back({19'(i + 1), a[i]});
        end
        settle();
    endtask
    task automatic s_lanes();
        sram_pkg::lanes_t m[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h6};
        sram_pkg::word_t e;
        foreach (m[k]) begin
            e = 36'hFFFFFFFFF;
            for (int j = 0; j < 4; j++) if (m[k][j]) begin
                e[8*j +: 8] = 8'h0;
                e[32 + j] = 1'h0;
            end
            issue(sram_pkg::CMD_WRITE, 17'h00100, 4'hF, 36'hFFFFFFFFF);
            issue(sram_pkg::CMD_WRITE, 17'h00100, m[k], 36'h0);
            issue(sram_pkg::CMD_READ, 17'h00100, 4'h0, 36'h0);
            want.push_back(e);
        end
        settle();
    endtask
    // write a burst from one start, read it back from another start past the wrap
    task automatic s_burst();
        sram_pkg::word_t m[4];
        logic [1:0] s;
        for (int o = 0; o < 2; o++) begin
            @(negedge clk);
            interleaved = o[0];
            s = 2'(o + 1);
            for (int i = 0; i < 4; i++) begin
                m[seq(s, i)] = {19'(o * 4 + i + 7), 17'h04444};
                issue(i == 0 ? sram_pkg::CMD_WRITE : sram_pkg::CMD_ADVANCE, {15'h1111, s}, 4'hF, m[seq(s, i)]);
            end
            for (int i = 0; i < 5; i++) begin
                issue(i == 0 ? sram_pkg::CMD_READ : sram_pkg::CMD_ADVANCE, {15'h1111, ~s}, 4'h0, 36'h0);
                want.push_back(m[seq(~s, i % 4)]);
            end
            settle();
        end
    endtask
    // relies on the interleaved burst left by s_burst: words 13, 14, 11 at offsets 0, 1, 2
    task automatic s_suspend();
        issue(sram_pkg::CMD_READ, 17'h04444, 4'h0, 36'h0);
        issue(sram_pkg::CMD_ADVANCE, 17'h0, 4'h0, 36'h0);
        @(negedge clk) hold = 1'h1;
        repeat (3) @(negedge clk);
        check("ready in hold", 36'h0, 36'(cmdReady));
        hold = 1'h0;
        want = '{{19'(13), 17'h04444}, {19'(14), 17'h04444}, {19'(11), 17'h04444}};
        settle();
    endtask
    task automatic s_stop();
        issue(sram_pkg::CMD_READ, 17'h0AAAA, 4'h0, 36'h0);
        issue(sram_pkg::CMD_STOP, 17'h0, 4'h0, 36'h0);
        issue(sram_pkg::CMD_ADVANCE, 17'h0, 4'h0, 36'h0);
        issue(sram_pkg::CMD_ADVANCE, 17'h0, 4'h0, 36'h0);
        @(negedge clk);
        check("bus after noop", 36'h0, 36'(sram_bus_if_inst.dataDriven));
        want.push_back({19'(3), 17'h0AAAA});
        settle();
    endtask
    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        check("oe at power-up", 36'h0, 36'(sram_bus_if_inst.devDataOe));
        resetn = 1'h1;
        s_write_read();
        s_lanes();
        s_burst();
        s_suspend();
        s_stop();
        report_and_stop();
    end
    // the scenarios need about 100 cycles; this leaves a wide margin
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
